// File: logic/thermal_pkg.sv
// Package of constants shared by the thermal replica files.
`default_nettype none
package thermal_pkg;
	// =============================================================
	// Register byte offsets.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_INIT = 8'h04;
	localparam logic [7:0] ADDR_STATE = 8'h08;
	localparam logic [7:0] ADDR_IEQ = 8'h0C;
	localparam logic [7:0] ADDR_FLAGS = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
	localparam logic [7:0] ADDR_GRP1 = 8'h20;
	localparam logic [7:0] ADDR_GRP2 = 8'h30;
	// Offsets inside a group block.
	localparam logic [3:0] GOFF_FLC = 4'h0;
	localparam logic [3:0] GOFF_TE = 4'h4;
	localparam logic [3:0] GOFF_TR = 4'h8;
	localparam logic [3:0] GOFF_THR = 4'hC;
	// =============================================================
	// Control and event bit positions.
	localparam int CTRL_EN = 0;
	localparam int CTRL_GRP = 1;
	localparam int CTRL_COOL = 2;
	localparam int CTRL_LOAD = 3;
	localparam int EV_ALARM = 0;
	localparam int EV_TRIP = 1;
	localparam int EV_RESET = 2;
	localparam int EV_N = 3;
	// =============================================================
	// Reset values of the group settings.
	localparam logic [15:0] RST_FLC = 16'h0100;
	localparam logic [15:0] RST_TC_MIN = 16'h000A;
	localparam logic [7:0] RST_TRIP_PCT = 8'h64;
	localparam logic [7:0] RST_ALARM_PCT = 8'h46;
	// =============================================================
	// Model and timing constants.
	localparam int FRAC_BITS = 16;
	localparam int K_FRAC = 8;
	localparam logic [6:0] K_NUM = 7'h69;
	localparam logic [6:0] K_DEN = 7'h64;
	localparam logic [6:0] PCT_FULL = 7'h64;
	localparam logic [13:0] PCT_SQ = 14'h2710;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_MS = 20;
	localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam int MS_PER_MIN = 60000;
	localparam logic [11:0] TICKS_PER_MIN = 12'(MS_PER_MIN / TICK_MS);
	// Update sequencer states.
	typedef enum logic [1:0] {S_IDLE, S_DIV_K, S_DIV_STEP, S_DIV_INIT} upd_state_t;
endpackage
`default_nettype wire

// File: logic/phase_max.sv
// Registered selection of the largest of three phase magnitudes.
`timescale 1ns/1ns
`default_nettype none
module phase_max #(
	parameter int W = 16
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_a,
	input wire logic [W-1:0] i_b,
	input wire logic [W-1:0] i_c,
	output logic [W-1:0] o_max
);
	logic [W-1:0] ab_max; // Larger of phases a and b.
	logic [W-1:0] max_q; // Largest phase, registered.

	// Compare the phases pairwise.
	always_comb begin
		ab_max = (i_a >= i_b) ? i_a : i_b;
	end

	// Hold the winner for one cycle so the output is a flop.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			max_q <= '0;
		end else begin
			max_q <= (ab_max >= i_c) ? ab_max : i_c;
		end
	end

	assign o_max = max_q;
endmodule
`default_nettype wire

// File: logic/seq_divider.sv
// Restoring divider taking one quotient bit per clock.
`timescale 1ns/1ns
`default_nettype none
module seq_divider #(
	parameter int W = 32
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic [W-1:0] i_num,
	input wire logic [W-1:0] i_den,
	output logic o_done,
	output logic [W-1:0] o_quo
);
	logic [W:0] rem_q; // Partial remainder.
	logic [W-1:0] quo_q; // Dividend shifting into quotient.
	logic [W-1:0] den_q; // Latched divisor.
	logic [$clog2(W+1)-1:0] cnt_q; // Bits still to produce.
	logic done_q; // One-cycle completion pulse.
	logic [W:0] shifted; // Remainder with next dividend bit.

	always_comb begin
		shifted = {rem_q[W-1:0], quo_q[W-1]};
	end

	// Iterate; a zero divisor yields an all-ones quotient.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rem_q <= '0;
			quo_q <= '0;
			den_q <= '0;
			cnt_q <= '0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (i_start) begin
				rem_q <= '0;
				quo_q <= i_num;
				den_q <= i_den;
				cnt_q <= ($clog2(W+1))'(W);
			end else if (cnt_q != '0) begin
				if (shifted >= {1'b0, den_q}) begin
					rem_q <= shifted - {1'b0, den_q};
					quo_q <= {quo_q[W-2:0], 1'b1};
				end else begin
					rem_q <= shifted;
					quo_q <= {quo_q[W-2:0], 1'b0};
				end
				cnt_q <= cnt_q - 1'b1;
				done_q <= (cnt_q == ($clog2(W+1))'(1));
			end
		end
	end

	assign o_done = done_q;
	assign o_quo = quo_q;
endmodule
`default_nettype wire

// File: logic/thermal_overload_replica.sv
// Thermal overload replica with AHB-Lite registers and interrupt.
`timescale 1ns/1ns
`default_nettype none
module thermal_overload_replica #(
	parameter int TICK_CYCLES = thermal_pkg::TICK_CYCLES,
	parameter int IW = 16
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_hsel,
	input wire logic [7:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	input wire logic [IW-1:0] i_phase_a,
	input wire logic [IW-1:0] i_phase_b,
	input wire logic [IW-1:0] i_phase_c,
	output logic o_alarm,
	output logic o_trip,
	output logic o_irq
);
	// =============================================================
	// Declarations.
	logic [31:0] ctrl_q; // Enable, group, cooling; load bit self-clears.
	logic [7:0] init_pct_q; // Initial state in percent.
	logic [15:0] flc_q [2]; // Full-load current per group.
	logic [15:0] te_q [2]; // Heating constant, minutes, per group.
	logic [15:0] tr_q [2]; // Cooling constant, minutes, per group.
	logic [7:0] trip_pct_q [2]; // Trip state percent per group.
	logic [7:0] alarm_pct_q [2]; // Alarm percent of trip per group.
	localparam int EV_N = thermal_pkg::EV_N;
	logic [EV_N-1:0] irq_stat_q; // Sticky events.
	logic [EV_N-1:0] irq_mask_q; // Event enables.
	logic wr_pend_q; // A write data phase is due.
	logic [7:0] wr_addr_q; // Address of that write.
	logic [31:0] rdata_q; // Read data for the data phase.
	logic acc; // Valid word transfer in address phase.
	logic [IW-1:0] equivalent_phase_current; // Largest phase current.
	logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_q; // Update interval divider.
	logic tick_q; // One-cycle update strobe.
	thermal_pkg::upd_state_t st_q; // Update sequencer state.
	logic [31:0] theta_q; // Thermal state, unsigned 16.16.
	logic [31:0] target_q; // Squared overload ratio of last update.
	logic heat_q; // Last step moved the state upward.
	logic upd_done_q; // Pulse when a step update stores a new state; the initial load gives none.
	logic div_start; // Divider start.
	logic [31:0] div_num; // Divider dividend.
	logic [31:0] div_den; // Divider divisor.
	logic div_done; // Divider finished.
	logic [31:0] div_quo; // Divider result.
	logic grp; // Active group index.
	logic [15:0] kq; // Overload ratio, 8 fraction bits, saturated.
	logic [31:0] k2; // Squared ratio, 16 fraction bits.
	logic [31:0] absdiff; // Distance from state to target.
	logic [15:0] alarm_prod; // Alarm percent times trip percent, full width.
	logic [27:0] n_ticks; // Time constant in update intervals.
	logic alarm_q; // Alarm stage level.
	logic trip_q; // Trip stage level.
	logic load_req_q; // Pending initial-state load.

	// Converts minutes to update intervals, never below one minute.
	function automatic logic [27:0] min_to_ticks(input logic [15:0] m);
		logic [15:0] mm;
		mm = (m == 16'h0000) ? 16'h0001 : m;
		return 28'(mm * thermal_pkg::TICKS_PER_MIN);
	endfunction

	// Decodes the group slot of a byte address, or returns 0 for none.
	function automatic logic [2:0] grp_slot(input logic [7:0] a);
		if (a[7:4] == thermal_pkg::ADDR_GRP1[7:4]) begin
			return 3'h1;
		end else if (a[7:4] == thermal_pkg::ADDR_GRP2[7:4]) begin
			return 3'h2;
		end
		return 3'h0;
	endfunction

	// =============================================================
	// Bus slave: zero wait states, always OKAY.
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_hrdata = rdata_q;
	assign acc = i_hsel && i_hready && i_htrans[1] && (i_hsize == 3'h2);

	// Capture the address phase and prepare read data.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			rdata_q <= 32'h0000_0000;
		end else begin
			wr_pend_q <= acc && i_hwrite;
			if (acc) begin
				wr_addr_q <= i_haddr;
			end
			rdata_q <= 32'h0000_0000;
			if (acc && !i_hwrite) begin
				rdata_q <= read_mux(i_haddr);
			end
		end
	end

	// Read multiplexer; unmapped addresses read as zero.
	function automatic logic [31:0] read_mux(input logic [7:0] a);
		logic [2:0] s;
		s = grp_slot(a);
		if (s != 3'h0) begin
			case (a[3:0])
				thermal_pkg::GOFF_FLC: return {16'h0000, flc_q[s[1]]};
				thermal_pkg::GOFF_TE: return {16'h0000, te_q[s[1]]};
				thermal_pkg::GOFF_TR: return {16'h0000, tr_q[s[1]]};
				thermal_pkg::GOFF_THR: return {16'h0000, alarm_pct_q[s[1]], trip_pct_q[s[1]]};
				default: return 32'h0000_0000;
			endcase
		end
		case (a)
			thermal_pkg::ADDR_CTRL: return ctrl_q;
			thermal_pkg::ADDR_INIT: return {24'h000000, init_pct_q};
			thermal_pkg::ADDR_STATE: return theta_q;
			thermal_pkg::ADDR_IEQ: return 32'(equivalent_phase_current);
			thermal_pkg::ADDR_FLAGS: return {30'h0, trip_q, alarm_q};
			thermal_pkg::ADDR_IRQ_STAT: return 32'(irq_stat_q);
			thermal_pkg::ADDR_IRQ_MASK: return 32'(irq_mask_q);
			default: return 32'h0000_0000;
		endcase
	endfunction

	// Control and per-group setting registers.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_q <= 32'h0000_0000;
			init_pct_q <= 8'h00;
			irq_mask_q <= '0;
			for (int g = 0; g < 2; g++) begin
				flc_q[g] <= thermal_pkg::RST_FLC;
				te_q[g] <= thermal_pkg::RST_TC_MIN;
				tr_q[g] <= thermal_pkg::RST_TC_MIN;
				trip_pct_q[g] <= thermal_pkg::RST_TRIP_PCT;
				alarm_pct_q[g] <= thermal_pkg::RST_ALARM_PCT;
			end
		end else if (wr_pend_q) begin
			if (grp_slot(wr_addr_q) != 3'h0) begin
				case (wr_addr_q[3:0])
					thermal_pkg::GOFF_FLC: flc_q[grp_slot(wr_addr_q) == 3'h2] <= i_hwdata[15:0];
					thermal_pkg::GOFF_TE: te_q[grp_slot(wr_addr_q) == 3'h2] <= i_hwdata[15:0];
					thermal_pkg::GOFF_TR: tr_q[grp_slot(wr_addr_q) == 3'h2] <= i_hwdata[15:0];
					thermal_pkg::GOFF_THR: begin
						trip_pct_q[grp_slot(wr_addr_q) == 3'h2] <= i_hwdata[7:0];
						alarm_pct_q[grp_slot(wr_addr_q) == 3'h2] <= i_hwdata[15:8];
					end
					default: ;
				endcase
			end else begin
				case (wr_addr_q)
					thermal_pkg::ADDR_CTRL: ctrl_q <= {29'h0, i_hwdata[2:0]};
					thermal_pkg::ADDR_INIT: init_pct_q <= i_hwdata[7:0];
					thermal_pkg::ADDR_IRQ_MASK: irq_mask_q <= i_hwdata[EV_N-1:0];
					default: ;
				endcase
			end
		end
	end

	// Load request: set by a CTRL write, cleared when served.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			load_req_q <= 1'b0;
		end else if (wr_pend_q && (wr_addr_q == thermal_pkg::ADDR_CTRL)
				&& i_hwdata[thermal_pkg::CTRL_LOAD]) begin
			load_req_q <= 1'b1;
		end else if (st_q == thermal_pkg::S_IDLE) begin
			load_req_q <= 1'b0;
		end
	end

	// =============================================================
	// Equivalent current and update interval.
	phase_max #(
		.W(IW)
	) u_max (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_a(i_phase_a),
		.i_b(i_phase_b),
		.i_c(i_phase_c),
		.o_max(equivalent_phase_current)
	);

	// Divide the clock down to one strobe per update interval.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (tick_cnt_q == '0);
			if (tick_cnt_q == '0) begin
				tick_cnt_q <= ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);
			end else begin
				tick_cnt_q <= tick_cnt_q - 1'b1;
			end
		end
	end

	// =============================================================
	// Update arithmetic.
	assign grp = ctrl_q[thermal_pkg::CTRL_GRP];

	// Both factors are widened first, so the product keeps all sixteen bits.
	assign alarm_prod = {8'h00, alarm_pct_q[grp]} * {8'h00, trip_pct_q[grp]};

	// Saturate the ratio, square it and pick the constant.
	always_comb begin
		kq = (div_quo[31:16] != 16'h0000) ? 16'hFFFF : div_quo[15:0];
		k2 = kq * kq;
		absdiff = (k2 >= theta_q) ? (k2 - theta_q) : (theta_q - k2);
		if ((k2 < theta_q) && ctrl_q[thermal_pkg::CTRL_COOL]) begin
			n_ticks = min_to_ticks(tr_q[grp]);
		end else begin
			n_ticks = min_to_ticks(te_q[grp]);
		end
	end

	// Divider operands and start for each sequencer step.
	always_comb begin
		div_start = 1'b0;
		div_num = 32'h0000_0000;
		div_den = 32'h0000_0000;
		case (st_q)
			thermal_pkg::S_IDLE: begin
				if (load_req_q) begin
					div_start = 1'b1;
					div_num = {8'h00, init_pct_q, 16'h0000};
					div_den = 32'(thermal_pkg::PCT_FULL);
				end else if (tick_q && ctrl_q[thermal_pkg::CTRL_EN]) begin
					div_start = 1'b1;
					div_num = 32'({equivalent_phase_current, 8'h00} * thermal_pkg::K_DEN);
					div_den = 32'(flc_q[grp] * thermal_pkg::K_NUM);
				end
			end
			thermal_pkg::S_DIV_K: begin
				div_start = div_done;
				div_num = absdiff;
				div_den = 32'(n_ticks);
			end
			default: ;
		endcase
	end

	seq_divider #(
		.W(32)
	) u_div (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_start(div_start),
		.i_num(div_num),
		.i_den(div_den),
		.o_done(div_done),
		.o_quo(div_quo)
	);

	// Sequencer: ratio, step toward target, or initial load.
	// One minus exp(-t/T) is taken as 1/N, N = T in intervals.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q <= thermal_pkg::S_IDLE;
			theta_q <= 32'h0000_0000;
			target_q <= 32'h0000_0000;
			heat_q <= 1'b0;
			upd_done_q <= 1'b0;
		end else begin
			upd_done_q <= 1'b0;
			case (st_q)
				thermal_pkg::S_IDLE: begin
					if (load_req_q) begin
						st_q <= thermal_pkg::S_DIV_INIT;
					end else if (div_start) begin
						st_q <= thermal_pkg::S_DIV_K;
					end
				end
				thermal_pkg::S_DIV_K: begin
					if (div_done) begin
						target_q <= k2;
						heat_q <= (k2 >= theta_q);
						st_q <= thermal_pkg::S_DIV_STEP;
					end
				end
				thermal_pkg::S_DIV_STEP: begin
					if (div_done) begin
						if (heat_q) begin
							theta_q <= theta_q + div_quo;
						end else if (div_quo > theta_q) begin
							theta_q <= 32'h0000_0000;
						end else begin
							theta_q <= theta_q - div_quo;
						end
						upd_done_q <= 1'b1;
						st_q <= thermal_pkg::S_IDLE;
					end
				end
				thermal_pkg::S_DIV_INIT: begin
					if (div_done) begin
						theta_q <= div_quo;
						st_q <= thermal_pkg::S_IDLE;
					end
				end
				default: st_q <= thermal_pkg::S_IDLE;
			endcase
		end
	end

	// =============================================================
	// Alarm and trip stages: levels that follow the state both ways.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			alarm_q <= 1'b0;
			trip_q <= 1'b0;
		end else begin
			trip_q <= (48'(theta_q) * thermal_pkg::PCT_FULL)
				>= 48'({trip_pct_q[grp], 16'h0000});
			alarm_q <= (48'(theta_q) * thermal_pkg::PCT_SQ)
				>= 48'({alarm_prod, 16'h0000});
		end
	end
	assign o_alarm = alarm_q;
	assign o_trip = trip_q;

	// Sticky events; a new event wins over a write-one clear.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_stat_q <= '0;
		end else begin
			logic [EV_N-1:0] ev;
			logic [EV_N-1:0] clr;
			ev = '0;
			ev[thermal_pkg::EV_ALARM] = (48'(theta_q) * thermal_pkg::PCT_SQ)
				>= 48'({alarm_prod, 16'h0000}) && !alarm_q;
			ev[thermal_pkg::EV_TRIP] = (48'(theta_q) * thermal_pkg::PCT_FULL)
				>= 48'({trip_pct_q[grp], 16'h0000}) && !trip_q;
			ev[thermal_pkg::EV_RESET] = trip_q && ((48'(theta_q) * thermal_pkg::PCT_FULL)
				< 48'({trip_pct_q[grp], 16'h0000}));
			clr = (wr_pend_q && (wr_addr_q == thermal_pkg::ADDR_IRQ_STAT))
				? i_hwdata[EV_N-1:0] : '0;
			irq_stat_q <= (irq_stat_q & ~clr) | ev;
		end
	end
	assign o_irq = |(irq_stat_q & irq_mask_q);

	// =============================================================
	// Assertions and covers.
	a_tick_reload: assert property (@(posedge i_clk) disable iff (i_rst)
		tick_q |-> $past(tick_cnt_q) == '0 && tick_cnt_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1))
		else $error("tick not on divider reload");
	a_ieq_largest: assert property (@(posedge i_clk) disable iff (i_rst)
		##1 (equivalent_phase_current >= $past(i_phase_a) && equivalent_phase_current >= $past(i_phase_b) && equivalent_phase_current >= $past(i_phase_c)
		&& (equivalent_phase_current == $past(i_phase_a) || equivalent_phase_current == $past(i_phase_b) || equivalent_phase_current == $past(i_phase_c))))
		else $error("equivalent current not largest phase");
	a_update_bound: assert property (@(posedge i_clk) disable iff (i_rst)
		(st_q == thermal_pkg::S_DIV_K) |-> ##[1:70] upd_done_q)
		else $error("update did not finish");
	a_step_toward: assert property (@(posedge i_clk) disable iff (i_rst)
		upd_done_q |-> (heat_q ? (theta_q >= $past(theta_q) && theta_q <= target_q)
		: (theta_q <= $past(theta_q) && theta_q >= target_q)))
		else $error("state left interval toward target");
	a_trip_level: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(trip_q) |-> $past(48'(theta_q) * thermal_pkg::PCT_FULL
		>= 48'({trip_pct_q[grp], 16'h0000})))
		else $error("trip rose below threshold");
	a_trip_drop: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(trip_q) |-> irq_stat_q[thermal_pkg::EV_RESET])
		else $error("trip release not recorded");
	a_init_load: assert property (@(posedge i_clk) disable iff (i_rst)
		(st_q == thermal_pkg::S_DIV_INIT && div_done) |=>
		32'(theta_q * thermal_pkg::PCT_FULL) <= {8'h00, init_pct_q, 16'h0000})
		else $error("initial state mis-scaled");
	a_alarm_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(alarm_q) |-> irq_stat_q[thermal_pkg::EV_ALARM])
		else $error("alarm event lost");
	a_irq_held: assert property (@(posedge i_clk) disable iff (i_rst)
		(o_irq && !wr_pend_q) |=> o_irq || $changed(irq_mask_q))
		else $error("interrupt dropped without clear");
	c_trip: cover property (@(posedge i_clk) disable iff (i_rst) $rose(trip_q));
	c_alarm: cover property (@(posedge i_clk) disable iff (i_rst) $rose(alarm_q));
	c_cool: cover property (@(posedge i_clk) disable iff (i_rst) upd_done_q && !heat_q);
	c_group2: cover property (@(posedge i_clk) disable iff (i_rst) upd_done_q && grp);
endmodule
`default_nettype wire

// File: tb/phase_source.sv
// Model of the phase current front end that feeds the relay.
`timescale 1ns/1ns
`default_nettype none
module phase_source (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [15:0] i_mag,
	input wire logic [1:0] i_lead,
	output logic [15:0] o_a,
	output logic [15:0] o_b,
	output logic [15:0] o_c
);
	// =============================================================
	// Phase levels.
	// The leading phase carries the full magnitude and the others carry less.
	// Each phase has its own lesser value, so a wrong pick shows up.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_a <= 16'h0000;
			o_b <= 16'h0000;
			o_c <= 16'h0000;
		end else begin
			o_a <= (i_lead == 2'h0) ? i_mag : i_mag >> 1;
			o_b <= (i_lead == 2'h1) ? i_mag : i_mag >> 2;
			o_c <= (i_lead == 2'h2) ? i_mag : i_mag >> 3;
		end
	end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the thermal overload replica.
`timescale 1ns/1ns
`default_nettype none
module tb;
	// =============================================================
	// Settings and signals.
	localparam int TICK = 200; // Shortened update period in cycles.
	localparam logic [7:0] G2_FLC = thermal_pkg::ADDR_GRP2 + 8'(thermal_pkg::GOFF_FLC);
	localparam logic [7:0] G2_TE = thermal_pkg::ADDR_GRP2 + 8'(thermal_pkg::GOFF_TE);
	localparam logic [7:0] G2_TR = thermal_pkg::ADDR_GRP2 + 8'(thermal_pkg::GOFF_TR);
	localparam logic [7:0] G2_THR = thermal_pkg::ADDR_GRP2 + 8'(thermal_pkg::GOFF_THR);
	localparam logic [7:0] G1_TE = thermal_pkg::ADDR_GRP1 + 8'(thermal_pkg::GOFF_TE);
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic hresp;
	logic [31:0] hrdata;
	logic [15:0] mag = 16'h0000;
	logic [1:0] lead = 2'h0;
	logic [15:0] pa, pb, pc;
	logic alarm, trip, irq;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;

	// The clock toggles every half period of 5 ns.
	initial begin
		forever #5 clk = ~clk;
	end

	// Cycle counter used to time the update period.
	always @(posedge clk) begin
		cyc <= cyc + 1;
	end

	phase_source u_src (.i_clk(clk), .i_rst(rst), .i_mag(mag), .i_lead(lead),
		.o_a(pa), .o_b(pb), .o_c(pc));

	thermal_overload_replica #(.TICK_CYCLES(TICK), .IW(16)) u_dut (.i_clk(clk), .i_rst(rst),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
		.o_hresp(hresp), .o_hrdata(hrdata), .i_phase_a(pa), .i_phase_b(pb),
		.i_phase_c(pc), .o_alarm(alarm), .o_trip(trip), .o_irq(irq));

	// =============================================================
	// Reporting and comparison.
	// Prints the counts and the verdict, then stops the run.
	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Counts and prints one mismatch.
	task automatic fail(input string msg);
		err_count++;
		$display("BAD %0t %s", $time, msg);
	endtask

	// Compares a word against an expectation with a tolerance for rounding.
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input int tol);
		check_count++;
		if (got + tol >= exp && got <= exp + tol) begin
		end else begin
			fail($sformatf("value %0h, expected %0h", got, exp));
		end
	endtask

	// Compares a single flag.
	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			fail($sformatf("flag %b, expected %b", got, exp));
		end
	endtask

	// =============================================================
	// Bus access.
	// Waits for an edge with ready high; a hang ends the run.
	task automatic ready_edge();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 100);
		if (hready !== 1'b1) begin
			fail("bus hang");
			end_of_test();
		end
	endtask

	// One single word transfer: address phase, then data phase.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		ready_edge();
		htrans <= 2'h0;
		hwdata <= wd;
		ready_edge();
		rd = hrdata;
		chk_bit(hresp, 1'b0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus(1'b0, a, 32'h0, d);
	endtask

	// Polls a register until its masked value equals v, or differs when ne is set.
	task automatic wait_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v,
			input logic ne, output logic [31:0] d);
		int n;
		n = 0;
		do begin
			rd(a, d);
			n++;
		end while ((((d & m) === v) == ne) && n < 3000);
		if (((d & m) === v) == ne) begin
			fail("register wait expired");
			end_of_test();
		end
	endtask

	// =============================================================
	// Scenarios.
	// Reset values, a read-only register and an unmapped address.
	task automatic t_reset();
		logic [31:0] d;
		rd(G1_TE, d);
		chk_val(d, 32'(thermal_pkg::RST_TC_MIN), 0);
		rd(G2_THR, d);
		chk_val(d, {16'h0, thermal_pkg::RST_ALARM_PCT, thermal_pkg::RST_TRIP_PCT}, 0);
		rd(G2_FLC, d);
		chk_val(d, 32'(thermal_pkg::RST_FLC), 0);
		wr(thermal_pkg::ADDR_STATE, 32'hFFFFFFFF);
		rd(thermal_pkg::ADDR_STATE, d);
		chk_val(d, 32'h0, 0);
		rd(8'hFC, d);
		chk_val(d, 32'h0, 0);
		chk_bit(irq, 1'b0);
	endtask

	// The largest phase feeds the model whichever phase leads.
	task automatic t_max();
		logic [31:0] d;
		for (int i = 0; i < 3; i++) begin
			lead <= 2'(i);
			mag <= 16'h0D1E + 16'(i);
			wait_reg(thermal_pkg::ADDR_IEQ, 32'hFFFF, 32'h0D1E + i, 1'b0, d);
			chk_val(d, 32'h0D1E + i, 0);
		end
	endtask

	// An initial state of 30 percent is held as 0.3 in 16.16 form.
	task automatic t_init();
		logic [31:0] d;
		wr(thermal_pkg::ADDR_INIT, 32'h1E);
		wr(thermal_pkg::ADDR_CTRL, 32'h8);
		wait_reg(thermal_pkg::ADDR_STATE, 32'hFFFFFFFF, 32'h0, 1'b1, d);
		chk_val(d, 32'(30 * 65536 / 100), 1);
		wr(thermal_pkg::ADDR_INIT, 32'h0);
		wr(thermal_pkg::ADDR_CTRL, 32'h8);
		wait_reg(thermal_pkg::ADDR_STATE, 32'hFFFFFFFF, 32'h0, 1'b0, d);
	endtask

	// Heating with group two and a one minute constant, up to alarm and trip.
	task automatic t_heat();
		logic [31:0] d, e, kk, tgt;
		int t1;
		kk = (32'h0D20 * 100 * 256) / (105 * 32'h100);
		tgt = kk * kk;
		wr(G2_FLC, 32'h100);
		wr(G2_TE, 32'h1);
		wr(thermal_pkg::ADDR_IRQ_MASK, 32'h3);
		wr(thermal_pkg::ADDR_CTRL, 32'h3);
		wait_reg(thermal_pkg::ADDR_STATE, 32'hFFFFFFFF, 32'h0, 1'b1, d);
		t1 = cyc;
		chk_val(d, tgt / 3000, 2);
		wait_reg(thermal_pkg::ADDR_STATE, 32'hFFFFFFFF, d, 1'b1, e);
		chk_val(e, d + (tgt - d) / 3000, 3);
		chk_val(32'(cyc - t1), TICK, 4);
		wait_reg(thermal_pkg::ADDR_FLAGS, 32'h1, 32'h1, 1'b0, d);
		rd(thermal_pkg::ADDR_STATE, e);
		chk_bit(e >= 32'd45876, 1'b1);
		chk_bit(alarm, 1'b1);
		chk_bit(trip, 1'b0);
		wait_reg(thermal_pkg::ADDR_FLAGS, 32'h2, 32'h2, 1'b0, d);
		rd(thermal_pkg::ADDR_STATE, e);
		chk_bit(e >= 32'h10000, 1'b1);
		rd(thermal_pkg::ADDR_IRQ_STAT, d);
		chk_val(d, 32'h3, 0);
		chk_bit(irq, 1'b1);
		wr(thermal_pkg::ADDR_IRQ_STAT, 32'h3);
		@(posedge clk);
		chk_bit(irq, 1'b0);
		wr(thermal_pkg::ADDR_IRQ_MASK, 32'h4);
	endtask

	// Reload to half, flags fall, then the cooling constant sets the decay.
	task automatic t_cool();
		logic [31:0] d;
		mag <= 16'h0000;
		wr(G2_TE, 32'hA);
		wr(G2_TR, 32'h1);
		wr(thermal_pkg::ADDR_INIT, 32'h32);
		wr(thermal_pkg::ADDR_CTRL, 32'hF);
		wait_reg(thermal_pkg::ADDR_STATE, 32'hFFFFFFFF, 32'h8000, 1'b0, d);
		wait_reg(thermal_pkg::ADDR_FLAGS, 32'h3, 32'h0, 1'b0, d);
		chk_bit(alarm, 1'b0);
		chk_bit(trip, 1'b0);
		chk_bit(irq, 1'b1);
		wr(thermal_pkg::ADDR_IRQ_MASK, 32'h0);
		@(posedge clk);
		chk_bit(irq, 1'b0);
		wait_reg(thermal_pkg::ADDR_STATE, 32'hFFFFFFFF, 32'h8000, 1'b1, d);
		chk_val(32'h8000 - d, 32'h8000 / 3000, 1);
	endtask

	// =============================================================
	// Main sequence.
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_max();
		t_init();
		t_heat();
		t_cool();
		end_of_test();
	end
endmodule
`default_nettype wire
